// ---- dv/host_pins.sv ----
// host-side pin model: pull-ups on gpio, trigger and load strobes
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  input  wire logic       aclk,
  input  wire logic [5:0] gpio_oe,
  input  wire logic [5:0] gpio_out,
  input  wire logic [5:0] ext_low,
  output var  logic [5:0] gpio_in,
  output var  logic       ext_trigger,
  output var  logic       ext_dac_load
);
  // open drain with pull-up: a released pin reads high
  always_comb begin
    gpio_in = ~((gpio_oe & ~gpio_out) | ext_low);
  end

  initial begin
    ext_trigger  = 1'b0;
    ext_dac_load = 1'b0;
  end

  // long high phase so the synchronizer sees one clean edge
  task automatic pulse(input int which);
    @(posedge aclk);
    if (which != 0) begin
      ext_dac_load <= 1'b1;
    end else begin
      ext_trigger <= 1'b1;
    end
    repeat (10) @(posedge aclk);
    ext_trigger  <= 1'b0;
    ext_dac_load <= 1'b0;
  endtask
endmodule // host_pins
`default_nettype wire

// ---- dv/monitor_digital_io_pins_properties.sv ----
// port-level checker for the digital pin block
`timescale 1ns/1ps
`default_nettype none
module dio_checker #(
  parameter integer NPINS  = 6,
  parameter integer NALARM = 4,
  parameter integer NDAC   = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              clk_en,
  input wire logic              conv_group_done,
  input wire logic [NALARM-1:0] channel_alarm,
  input wire logic              conv_start,
  input wire logic [NDAC-1:0]   dac_update,
  input wire logic              data_valid_n,
  input wire logic              global_alarm_n,
  input wire logic              ext_dac_load,
  input wire logic [NPINS-1:0]  gpio_out,
  input wire logic [NPINS-1:0]  gpio_oe,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);

  done_low_a: assert property (
    conv_group_done |-> ##[1:3] !data_valid_n)
    else $error("data valid not asserted after group done");
  global_alarm_n_set_a: assert property (
    conv_group_done && |channel_alarm |-> ##[1:3] !global_alarm_n)
    else $error("global alarm not low with alarm bits set");
  global_alarm_n_clear_a: assert property (
    conv_group_done && channel_alarm == 0 |-> ##[1:3] global_alarm_n)
    else $error("global alarm low with no alarm bits");
  od_drive_a: assert property (gpio_out == 0)
    else $error("gpio driven high");
  reset_pins_a: assert property (
    @(posedge aclk) disable iff (!clk_en) !aresetn
    |=> data_valid_n && global_alarm_n && gpio_oe == 0 && !irq)
    else $error("pins not released by reset");
  start_once_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  load_once_a: assert property (|dac_update |=> dac_update == 0)
    else $error("dac update longer than one cycle");
  load_cause_a: assert property (
    |dac_update |-> $past(ext_dac_load, 2) && $past(ext_dac_load, 3))
    else $error("dac update without load strobe");
endmodule // dio_checker

bind monitor_digital_io_pins dio_checker #(.NPINS(NPINS), .NALARM(NALARM),
  .NDAC(NDAC)) chk (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .conv_group_done(conv_group_done), .channel_alarm(channel_alarm),
  .conv_start(conv_start), .dac_update(dac_update),
  .data_valid_n(data_valid_n), .global_alarm_n(global_alarm_n),
  .ext_dac_load(ext_dac_load), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
  .irq(irq));
`default_nettype wire

// ---- dv/test_monitor_digital_io_pins.sv ----
// self-checking bench for the digital pin block
`timescale 1ns/1ps
`default_nettype none
`include "dio_consts.vh"
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_monitor_digital_io_pins;
  logic        aclk, aresetn, cgd, awv, wv, bvr, arv, rr, ce;
  logic        awr, wrd, bv, arr, rv, cst, dvn, galn, trg, ld, irq;
  logic [7:0]  awa, ara, dacu, dac_last;
  logic [31:0] wd, rdat, rd_q;
  logic [1:0]  br, rrs, rs_q, bq;
  logic [3:0]  alm;
  logic [5:0]  gin, gout, goe, ext_low;
  int          n_fail, compares, n_start, n_dac, low_n, s0;

  monitor_digital_io_pins dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(ce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bvr), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .conv_group_done(cgd), .channel_alarm(alm), .conv_start(cst),
    .dac_update(dacu), .data_valid_n(dvn), .global_alarm_n(galn),
    .ext_trigger(trg), .ext_dac_load(ld), .gpio_in(gin),
    .gpio_out(gout), .gpio_oe(goe), .irq(irq));
  host_pins host (.aclk(aclk), .gpio_oe(goe), .gpio_out(gout),
    .ext_low(ext_low), .gpio_in(gin), .ext_trigger(trg),
    .ext_dac_load(ld));

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // tallies every edge, since start and update are one-cycle pulses
  always @(posedge aclk) begin
    n_start <= n_start + int'(cst);
    n_dac <= n_dac + int'(dacu != 0);
    dac_last <= (dacu != 0) ? dacu : dac_last;
    low_n <= low_n + int'(!dvn);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    do @(posedge aclk); while (!(awr === 1 && wrd === 1));
    awv <= 0; wv <= 0; bvr <= 1;
    do @(posedge aclk); while (bv !== 1);
    bq = br;
    bvr <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1;
    do @(posedge aclk); while (arr !== 1);
    arv <= 0; rr <= 1;
    do @(posedge aclk); while (rv !== 1);
    rd_q = rdat; rs_q = rrs; rr <= 0;
  endtask

  task automatic done(input logic [3:0] a);
    @(posedge aclk);
    alm <= a; cgd <= 1;
    @(posedge aclk);
    cgd <= 0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic reset_chk();
    aresetn <= 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK(goe, 6'h00)
    rd(`OFF_GPIO); `CHK({rd_q[11:8], rd_q[5:0]}, 10'h3FF)
  endtask

  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog: whole run is under two thousand cycles, allow ten times that
  initial begin
    #200_000;
    n_fail++;
    summarize();
  end

  initial begin
    {cgd, awv, wv, bvr, arv, rr} = 0;
    {awa, ara, wd, alm, ext_low} = 0;
    {n_fail, compares, n_start, n_dac, low_n} = 0;
    dac_last = 0;
    ce = 1;
    reset_chk();
    wr(`OFF_GPIO, 32'h0000_0F2A);
    `CHK(bq, `RESP_OKAY)
    repeat (4) @(posedge aclk);
    `CHK(goe, 6'h15)
    rd(`OFF_GPIO); `CHK(rd_q[5:0], 6'h2A)
    wr(`OFF_GPIO, 32'h0000_0F3F);
    ext_low <= 6'h20;
    repeat (4) @(posedge aclk);
    rd(`OFF_GPIO); `CHK(rd_q[5:0], 6'h1F)
    ext_low <= 0;
    wr(`OFF_GPIO, 32'h0000_003F); done(4'h5);
    `CHK(goe, 6'h05)
    `CHK(galn, 1'b0)
    `CHK(dvn, 1'b0)
    rd(`OFF_GPIO); `CHK(rd_q[3:0], 4'hA)
    rd(`OFF_STATUS); `CHK(rd_q[13], 1'b1)
    rd(`OFF_ADC_DATA); repeat (2) @(posedge aclk);
    `CHK(dvn, 1'b1)
    done(4'h0); `CHK(galn, 1'b1)
    `CHK(goe, 6'h00)
    `CHK(dvn, 1'b0)
    wr(`OFF_STATUS, 32'h0000_0000); repeat (2) @(posedge aclk);
    `CHK(dvn, 1'b1)
    wr(`OFF_STATUS, 32'h0000_0020); done(4'h0); s0 = n_start;
    host.pulse(0); repeat (10) @(posedge aclk);
    `CHK(n_start - s0, 1)
    `CHK(dvn, 1'b1)
    wr(`OFF_STATUS, 32'h0000_0000); s0 = n_start;
    host.pulse(0); repeat (10) @(posedge aclk);
    `CHK(n_start - s0, 0)
    // software start must also clear a pending flag
    done(4'h0); `CHK(dvn, 1'b0)
    s0 = n_start;
    wr(`OFF_EVENTS, 32'h0000_0001); repeat (3) @(posedge aclk);
    `CHK(n_start - s0, 1)
    `CHK(dvn, 1'b1)
    wr(`OFF_SYNCLOAD, 32'h0000_00A5); s0 = n_dac;
    host.pulse(1); repeat (10) @(posedge aclk);
    `CHK(n_dac - s0, 1)
    `CHK(dac_last, 8'hA5)
    // a load edge while the clock enable is low is lost, not deferred
    ce <= 0; s0 = n_dac;
    host.pulse(1); repeat (4) @(posedge aclk);
    ce <= 1; repeat (10) @(posedge aclk);
    `CHK(n_dac - s0, 0)
    wr(`OFF_STATUS, 32'h0000_0010);
    for (int i = 0; i < 2; i++) begin
      s0 = low_n; done(4'h0); repeat (250) @(posedge aclk);
      `CHK(low_n - s0, `PULSE_NS / `CLK_NS)
    end
    rd(`OFF_STATUS); `CHK(rd_q[13], 1'b0)
    wr(`OFF_IRQ_MASK, 32'h0000_0001); done(4'h0); `CHK(irq, 1'b1)
    rd(`OFF_IRQ_STAT); `CHK(rd_q[0], 1'b1)
    repeat (3) @(posedge aclk); `CHK(irq, 1'b0)
    wr(`OFF_IRQ_MASK, 32'h0000_0000); done(4'h0); `CHK(irq, 1'b0)
    rd(8'h40); `CHK(rs_q, `RESP_SLVERR)
    wr(8'h40, 32'h0000_0000); `CHK(bq, `RESP_SLVERR)
    wr(`OFF_GPIO, 32'h0000_0000); repeat (4) @(posedge aclk);
    `CHK(goe, 6'h30)
    reset_chk();
    summarize();
  end
endmodule // test_monitor_digital_io_pins
`default_nettype wire

// ---- src/dio_consts.vh ----
// constants for the digital pin block: offsets, fields, resets, timing
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH

// register byte offsets
`define OFF_STATUS    8'h00
`define OFF_GPIO      8'h04
`define OFF_SYNCLOAD  8'h08
`define OFF_IRQ_STAT  8'h0C
`define OFF_IRQ_MASK  8'h10
`define OFF_ADC_DATA  8'h14
`define OFF_EVENTS    8'h18

// status/control fields
`define BIT_EXT_TRIGGER_ENABLE   5
`define BIT_AUTO    4
`define BIT_DATA_AVAIL_FLAG    13
`define BIT_RSTC    14
// gpio register: state in [5:0], function select in [11:8]
`define GPIO_ST_LSB 0
`define GPIO_FN_LSB 8

// irq status bits
`define IRQ_DONE    0
`define IRQ_ALARM   1
`define IRQ_TRIG    2
`define IRQ_LOAD    3

// reset values
`define RST_PIN_STATE 6'h3F
`define RST_PIN_FUNC  4'hF
`define RST_SYNCLOAD  8'h00

// pulse timing
`define PULSE_NS  2000
`define CLK_NS    10

// axi responses
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- src/monitor_digital_io_pins.v ----
// digital pin logic: data valid, global alarm, trigger, dac load, gpio
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dio_consts.vh"

// How it works
// - direct mode done sets flag, data_valid_n low
// - auto mode: 2us low pulse per sequence
// - global_alarm_n low if any alarm set
// - trigger rising edge starts conversion when enabled
// - load edge updates selected dacs together
// - six gpio pins, four dual purpose
// - function select 0 alarm, 1 gpio
// - alarm pin low on alarm, else released
// - gpio output open drain from state bit
// - gpio input reads pin level
// - reset: all function and state bits one
// - flag cleared by read, start, or write zero
// - alarm pins read back inverted alarm bit
module monitor_digital_io_pins #(
  parameter integer NPINS  = 6,
  parameter integer NALARM = 4,
  parameter integer NDAC   = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              clk_en,
  // axi4-lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // converter core side, same clock
  input  wire              conv_group_done,
  input  wire [NALARM-1:0] channel_alarm,
  output reg               conv_start,
  output reg  [NDAC-1:0]   dac_update,
  // pins
  output reg               data_valid_n,
  output reg               global_alarm_n,
  input  wire              ext_trigger,
  input  wire              ext_dac_load,
  input  wire [NPINS-1:0]  gpio_in,
  output reg  [NPINS-1:0]  gpio_out,
  output reg  [NPINS-1:0]  gpio_oe,
  output reg               irq
);

  localparam integer PULSE_CYC = (`PULSE_NS + `CLK_NS - 1) / `CLK_NS;
  localparam [15:0] PULSE_LEN = PULSE_CYC[15:0];

  // byte offset compare, used by both decode paths
  function is_off;
    input [7:0] a;
    input [7:0] off;
    begin
      is_off = (a[7:2] == off[7:2]);
    end
  endfunction

  // registers
  reg               ext_trigger_enable_r;
  reg               auto_mode_r;
  reg               data_avail_flag_r;
  reg               reset_done_r;
  reg [NPINS-1:0]   pin_state_bit_r;
  reg [NALARM-1:0]  pin_function_select_r;
  reg [NDAC-1:0]    sync_load_select_r;
  reg [3:0]         irq_stat_r;
  reg [3:0]         irq_mask_r;
  reg [15:0]        pulse_cnt_r;
  reg [NALARM-1:0]  alarm_r;

  // pin synchronisers, first stage read only by second
  reg [1:0]         trig_s_r;
  reg [1:0]         load_s_r;
  reg               trig_d_r;
  reg               load_d_r;
  reg [NPINS-1:0]   gpio_s1_r;
  reg [NPINS-1:0]   gpio_s2_r;

  wire trig_rise = trig_s_r[1] & ~trig_d_r;
  wire load_rise = load_s_r[1] & ~load_d_r;
  wire start_ext = trig_rise & ext_trigger_enable_r;
  wire any_alarm = |alarm_r;

  // axi handshakes
  wire wr_go = s_axi_awvalid & s_axi_wvalid & s_axi_awready & s_axi_wready;
  wire rd_go = s_axi_arvalid & s_axi_arready;

  wire wr_stat  = wr_go && is_off(s_axi_awaddr, `OFF_STATUS) && s_axi_wstrb[1];
  wire rd_data  = rd_go && is_off(s_axi_araddr, `OFF_ADC_DATA);
  wire rd_irq   = rd_go && is_off(s_axi_araddr, `OFF_IRQ_STAT);
  wire wr_start = wr_go && is_off(s_axi_awaddr, `OFF_EVENTS) &&
                  s_axi_wstrb[0] && s_axi_wdata[0];
  wire start_any = start_ext | wr_start;

  // readback of gpio state: alarm pins show inverted alarm, else pin
  reg [NPINS-1:0] gpio_rd;
  integer i;
  always @* begin
    gpio_rd = gpio_s2_r;
    for (i = 0; i < NALARM; i = i + 1) begin
      if (!pin_function_select_r[i]) begin
        gpio_rd[i] = ~alarm_r[i];
      end
    end
  end

  // pin synchronisers and edge memories
  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_s_r  <= 2'b00;
      load_s_r  <= 2'b00;
      trig_d_r  <= 1'b0;
      load_d_r  <= 1'b0;
      gpio_s1_r <= {NPINS{1'b1}};
      gpio_s2_r <= {NPINS{1'b1}};
    end else if (clk_en) begin
      trig_s_r  <= {trig_s_r[0], ext_trigger};
      load_s_r  <= {load_s_r[0], ext_dac_load};
      trig_d_r  <= trig_s_r[1];
      load_d_r  <= load_s_r[1];
      gpio_s1_r <= gpio_in;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  // axi write channel: accept both together, then respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (is_off(s_axi_awaddr, `OFF_STATUS) ||
            is_off(s_axi_awaddr, `OFF_GPIO) ||
            is_off(s_axi_awaddr, `OFF_SYNCLOAD) ||
            is_off(s_axi_awaddr, `OFF_IRQ_STAT) ||
            is_off(s_axi_awaddr, `OFF_IRQ_MASK) ||
            is_off(s_axi_awaddr, `OFF_ADC_DATA) ||
            is_off(s_axi_awaddr, `OFF_EVENTS)) begin
          s_axi_bresp <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end else if (!s_axi_bvalid && s_axi_awvalid && s_axi_wvalid &&
                   !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (is_off(s_axi_araddr, `OFF_STATUS)) begin
          s_axi_rdata[`BIT_RSTC]  <= reset_done_r;
          s_axi_rdata[`BIT_DATA_AVAIL_FLAG]  <= data_avail_flag_r;
          s_axi_rdata[`BIT_EXT_TRIGGER_ENABLE] <= ext_trigger_enable_r;
          s_axi_rdata[`BIT_AUTO]  <= auto_mode_r;
        end else if (is_off(s_axi_araddr, `OFF_GPIO)) begin
          s_axi_rdata[`GPIO_ST_LSB +: NPINS]  <= gpio_rd;
          s_axi_rdata[`GPIO_FN_LSB +: NALARM] <= pin_function_select_r;
        end else if (is_off(s_axi_araddr, `OFF_SYNCLOAD)) begin
          s_axi_rdata[NDAC-1:0] <= sync_load_select_r;
        end else if (is_off(s_axi_araddr, `OFF_IRQ_STAT)) begin
          s_axi_rdata[3:0] <= irq_stat_r;
        end else if (is_off(s_axi_araddr, `OFF_IRQ_MASK)) begin
          s_axi_rdata[3:0] <= irq_mask_r;
        end else if (is_off(s_axi_araddr, `OFF_ADC_DATA)) begin
          s_axi_rdata[NALARM-1:0] <= alarm_r;   // alarm snapshot
        end else if (is_off(s_axi_araddr, `OFF_EVENTS)) begin
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid && s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // control registers; a write of the reset-done bit as zero clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_trigger_enable_r  <= 1'b0;
      auto_mode_r           <= 1'b0;
      reset_done_r          <= 1'b1;
      pin_state_bit_r       <= `RST_PIN_STATE;
      pin_function_select_r <= `RST_PIN_FUNC;
      sync_load_select_r    <= `RST_SYNCLOAD;
      irq_mask_r            <= 4'h0;
    end else if (clk_en && wr_go) begin
      if (is_off(s_axi_awaddr, `OFF_STATUS)) begin
        if (s_axi_wstrb[0]) begin
          ext_trigger_enable_r <= s_axi_wdata[`BIT_EXT_TRIGGER_ENABLE];
          auto_mode_r          <= s_axi_wdata[`BIT_AUTO];
        end
        // host may clear but never set the reset-done bit
        if (s_axi_wstrb[1] && !s_axi_wdata[`BIT_RSTC]) begin
          reset_done_r <= 1'b0;
        end
      end else if (is_off(s_axi_awaddr, `OFF_GPIO)) begin
        if (s_axi_wstrb[0]) begin
          pin_state_bit_r <= s_axi_wdata[`GPIO_ST_LSB +: NPINS];
        end
        if (s_axi_wstrb[1]) begin
          pin_function_select_r <= s_axi_wdata[`GPIO_FN_LSB +: NALARM];
        end
      end else if (is_off(s_axi_awaddr, `OFF_SYNCLOAD)) begin
        if (s_axi_wstrb[0]) begin
          sync_load_select_r <= s_axi_wdata[NDAC-1:0];
        end
      end else if (is_off(s_axi_awaddr, `OFF_IRQ_MASK)) begin
        if (s_axi_wstrb[0]) begin
          irq_mask_r <= s_axi_wdata[3:0];
        end
      end
    end
  end

  // data-available flag, auto pulse, conversion start, dac load
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_avail_flag_r <= 1'b0;
      pulse_cnt_r       <= 16'h0000;
      conv_start        <= 1'b0;
      dac_update        <= {NDAC{1'b0}};
      alarm_r           <= {NALARM{1'b0}};
    end else if (clk_en) begin
      conv_start <= start_any;
      dac_update <= load_rise ? sync_load_select_r :
                    {NDAC{1'b0}};
      if (conv_group_done) begin
        alarm_r <= channel_alarm;   // alarms refresh per finished group
      end
      // set wins over the clears
      if (conv_group_done && !auto_mode_r) begin
        data_avail_flag_r <= 1'b1;
      end else if (auto_mode_r || rd_data || start_any ||
                   (wr_stat && !s_axi_wdata[`BIT_DATA_AVAIL_FLAG])) begin
        data_avail_flag_r <= 1'b0;
      end
      if (conv_group_done && auto_mode_r) begin
        pulse_cnt_r <= PULSE_LEN;
      end else if (pulse_cnt_r != 16'h0000) begin
        pulse_cnt_r <= pulse_cnt_r - 16'h0001;
      end
    end
  end

  // sticky interrupt status, cleared by a read; set wins
  wire [3:0] irq_set = {load_rise, start_ext, conv_group_done &
                        (|channel_alarm), conv_group_done};
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 4'h0;
      irq       <= 1'b0;
    end else if (clk_en) begin
      irq_stat_r <= (rd_irq ? 4'h0 : irq_stat_r) | irq_set;
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end

  // alarm function and bits widened to pin width; plain pins never alarm
  wire [NPINS-1:0] alarm_fn_pad = {{(NPINS-NALARM){1'b0}},
                                   ~pin_function_select_r};
  wire [NPINS-1:0] alarm_pad    = {{(NPINS-NALARM){1'b0}}, alarm_r};

  // pin outputs, all registered
  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      always @(posedge aclk) begin
        if (!aresetn) begin
          gpio_oe[g]  <= 1'b0;
          gpio_out[g] <= 1'b0;
        end else if (clk_en) begin
          gpio_out[g] <= 1'b0;                  // open drain, low only
          if (alarm_fn_pad[g]) begin
            gpio_oe[g] <= alarm_pad[g];
          end else begin
            gpio_oe[g] <= ~pin_state_bit_r[g];
          end
        end
      end
    end
  endgenerate

  // status pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      data_valid_n   <= 1'b1;
      global_alarm_n <= 1'b1;
    end else if (clk_en) begin
      data_valid_n   <= auto_mode_r ? (pulse_cnt_r == 16'h0000) :
                        ~data_avail_flag_r;
      global_alarm_n <= ~any_alarm;
    end
  end

endmodule // monitor_digital_io_pins
`default_nettype wire
